// File: hdl/adcc_defines.svh
`ifndef ADCC_DEFINES_SVH
`define ADCC_DEFINES_SVH
// ---------------------------------------------------------------
// Register indices and address width
// ---------------------------------------------------------------
`define ADCC_IDX_CTRL      8'hD0
`define ADCC_IDX_RESULT    8'hD1
`define ADCC_ADDR_W        10
// ---------------------------------------------------------------
// Control field positions
// ---------------------------------------------------------------
`define ADCC_BIT_IRQ_EN    7
`define ADCC_BIT_DONE      6
`define ADCC_BIT_START     5
`define ADCC_BIT_PWR       4
`define ADCC_BIT_OSC_OFF   2
`define ADCC_CTRL_RESET    8'h40
`define ADCC_WMASK         8'h94
// ---------------------------------------------------------------
// Conversion timing
// ---------------------------------------------------------------
`define ADCC_SAR_STEPS     8
`define ADCC_STEP_CYCLES   16
`define ADCC_FULL_SCALE    8'hFF
`define ADCC_ZERO_SCALE    8'h00
`endif

// File: hdl/adcc_pkg.sv
package adcc_pkg;
   // ------------------------------------------------------------
   // Types
   // ------------------------------------------------------------
   typedef enum logic [2:0] {
      ADCC_IDLE    = 3'b001,
      ADCC_SAMPLE  = 3'b010,
      ADCC_CONVERT = 3'b100
   } adcc_state_type;

   typedef struct packed {
      logic       hold;
      logic       below_low;
      logic       above_high;
   } adcc_analog_type;
endpackage

// File: hdl/adcc_sar.sv
`timescale 1ns/100ps
`include "adcc_defines.svh"
module adcc_sar
   import adcc_pkg::*;
#(
   parameter int STEP_CYCLES = `ADCC_STEP_CYCLES
) (
   input  wire logic       clk,
   input  wire logic       resetn,
   input  wire logic       ce,
   input  wire logic       go,
   input  wire logic       cmp_high,
   input  wire logic       halt,
   output logic            busy,
   output logic            finish,
   output logic [7:0]      trial,
   output logic [7:0]      code
);
   // ------------------------------------------------------------
   // Successive approximation sequencer
   // ------------------------------------------------------------
   logic [7:0]  bit_q;
   logic [7:0]  bit_d;
   logic [7:0]  acc_q;
   logic [7:0]  acc_d;
   logic [15:0] tick_q;
   logic [15:0] tick_d;
   logic        busy_q;
   logic        busy_d;
   logic        fin_q;
   logic        fin_d;
   wire  logic  step_end;
   wire  logic  last_bit;
   wire  logic [7:0] kept;

   assign step_end = (tick_q == 16'(STEP_CYCLES - 1));
   assign last_bit = bit_q[0];
   // Comparator high means input above trial, keep the bit
   assign kept     = cmp_high ? (acc_q | bit_q) : acc_q;
   assign trial    = acc_q | bit_q;
   assign busy     = busy_q;
   assign finish   = fin_q;
   assign code     = acc_q;

   always_comb begin
      bit_d  = bit_q;
      acc_d  = acc_q;
      tick_d = tick_q;
      busy_d = busy_q;
      fin_d  = 1'b0;
      if (go) begin
         bit_d  = 8'h80;
         acc_d  = 8'h00;
         tick_d = 16'h0000;
         busy_d = 1'b1;
      end else if (halt) begin
         busy_d = 1'b0;
      end else if (busy_q) begin
         if (step_end) begin
            tick_d = 16'h0000;
            acc_d  = kept;
            bit_d  = bit_q >> 1;
            if (last_bit) begin
               busy_d = 1'b0;
               fin_d  = 1'b1;
            end
         end else begin
            tick_d = tick_q + 16'h0001;
         end
      end
   end

   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         bit_q  <= 8'h00;
         acc_q  <= 8'h00;
         tick_q <= 16'h0000;
         busy_q <= 1'b0;
         fin_q  <= 1'b0;
      end else if (ce) begin
         bit_q  <= bit_d;
         acc_q  <= acc_d;
         tick_q <= tick_d;
         busy_q <= busy_d;
         fin_q  <= fin_d;
      end
   end
endmodule // adcc_sar

// File: hdl/adcc_top.sv
// Our own choice: the Avalon-MM interface to the registers.
`timescale 1ns/100ps
`include "adcc_defines.svh"
module adcc_top
   import adcc_pkg::*;
#(
   parameter int STEP_CYCLES = `ADCC_STEP_CYCLES
) (
   input  wire logic                      CLK,
   input  wire logic                      RESETN,
   input  wire logic                      CE,
   input  wire logic [`ADCC_ADDR_W-1:0]   AVS_ADDRESS,
   input  wire logic                      AVS_READ,
   input  wire logic                      AVS_WRITE,
   input  wire logic [31:0]               AVS_WRITEDATA,
   input  wire logic [3:0]                AVS_BYTEENABLE,
   output logic [31:0]                    AVS_READDATA,
   output logic                           AVS_WAITREQUEST,
   input  wire logic                      CMP_HIGH,
   input  wire logic                      ABOVE_HIGH_REF,
   input  wire logic                      BELOW_LOW_REF,
   input  wire logic                      WAIT_MODE,
   input  wire logic                      STOP_MODE,
   output logic [7:0]                     SAR_TRIAL,
   output logic                           CONV_ACTIVE,
   output logic                           CONVERTER_POWER_ON,
   output logic                           MAIN_OSC_DISABLE,
   output logic                           COMPLETION_IRQ,
   output logic                           WAKE_REQUEST
);
   // ------------------------------------------------------------
   // Bus decode
   // ------------------------------------------------------------
   localparam logic [7:0] ctrl_rst = `ADCC_CTRL_RESET;
   logic        ack_q;
   logic        wait_q;
   logic [31:0] rdata_q;
   logic        irq_en_q;
   logic        done_q;
   logic        pwr_q;
   logic        osc_off_q;
   logic [7:0]  result_q;
   logic [7:0]  trial_q;
   logic        active_q;
   logic        irq_q;
   logic        wake_q;
   logic        irq_en_d;
   logic        done_d;
   logic        pwr_d;
   logic        osc_off_d;
   logic [7:0]  result_d;
   wire  logic  req;
   wire  logic  wr_take;
   wire  logic  rd_take;
   wire  logic  hit_ctrl;
   wire  logic  hit_result;
   wire  logic  lane0;
   wire  logic [7:0] wbyte;
   wire  logic  start_hit;
   wire  logic  go;
   wire  logic  halt;
   wire  logic  finish;
   wire  logic  busy;
   wire  logic [7:0] trial;
   wire  logic [7:0] code;
   wire  logic [7:0] final_code;
   wire  logic [7:0] ctrl_view;
   wire  logic [31:0] rdata_d;
   adcc_analog_type  ana;

   // Byte addressed: index times four
   assign hit_ctrl   = (AVS_ADDRESS == `ADCC_ADDR_W'({`ADCC_IDX_CTRL, 2'b00}));
   assign hit_result = (AVS_ADDRESS == `ADCC_ADDR_W'({`ADCC_IDX_RESULT, 2'b00}));
   assign req        = (AVS_READ | AVS_WRITE) & ~ack_q;
   // Write lands on the answering edge; read data is fetched one cycle early
   assign wr_take    = AVS_WRITE & ack_q & CE;
   assign rd_take    = AVS_READ & ~ack_q & CE;
   assign lane0      = AVS_BYTEENABLE[0];
   assign wbyte      = AVS_WRITEDATA[7:0];

   // ------------------------------------------------------------
   // Converter control
   // ------------------------------------------------------------
   assign ana.hold       = 1'b0;
   assign ana.below_low  = BELOW_LOW_REF;
   assign ana.above_high = ABOVE_HIGH_REF;

   assign start_hit = wr_take & hit_ctrl & lane0 & wbyte[`ADCC_BIT_START];
   assign go        = start_hit & pwr_d & ~STOP_MODE;
   // stop mode or power off halts
   assign halt      = STOP_MODE | ~pwr_q;

   assign final_code = ana.above_high ? `ADCC_FULL_SCALE :
                       ana.below_low  ? `ADCC_ZERO_SCALE : code;

   // start reads zero, unused bits too
   assign ctrl_view = {irq_en_q, done_q, 1'b0, pwr_q, 1'b0, osc_off_q, 2'b00};
   assign rdata_d   = hit_ctrl   ? {24'h0000_00, ctrl_view} :
                      hit_result ? {24'h0000_00, result_q}  : 32'h0000_0000;

   adcc_sar #(
      .STEP_CYCLES (STEP_CYCLES)
   ) u_sar (
      .clk      (CLK),
      .resetn   (RESETN),
      .ce       (CE),
      .go       (go),
      .cmp_high (CMP_HIGH),
      .halt     (halt),
      .busy     (busy),
      .finish   (finish),
      .trial    (trial),
      .code     (code)
   );

   always_comb begin
      irq_en_d  = irq_en_q;
      done_d    = done_q;
      pwr_d     = pwr_q;
      osc_off_d = osc_off_q;
      result_d  = result_q;
      if (wr_take & hit_ctrl & lane0) begin
         irq_en_d  = wbyte[`ADCC_BIT_IRQ_EN];
         pwr_d     = wbyte[`ADCC_BIT_PWR];
         osc_off_d = wbyte[`ADCC_BIT_OSC_OFF];
      end
      if (go) begin
         done_d = 1'b0;
      end else if (finish) begin
         done_d   = 1'b1;
         result_d = final_code;
      end
   end

   // ------------------------------------------------------------
   // Registers
   // ------------------------------------------------------------
   always_ff @(posedge CLK or negedge RESETN) begin
      if (!RESETN) begin
         irq_en_q  <= ctrl_rst[`ADCC_BIT_IRQ_EN];
         done_q    <= ctrl_rst[`ADCC_BIT_DONE];
         pwr_q     <= ctrl_rst[`ADCC_BIT_PWR];
         osc_off_q <= ctrl_rst[`ADCC_BIT_OSC_OFF];
         result_q  <= 8'h00;
      end else if (CE) begin
         irq_en_q  <= irq_en_d;
         done_q    <= done_d;
         pwr_q     <= pwr_d;
         osc_off_q <= osc_off_d;
         result_q  <= result_d;
      end
   end

   always_ff @(posedge CLK or negedge RESETN) begin
      if (!RESETN) begin
         ack_q   <= 1'b0;
         wait_q  <= 1'b1;
         rdata_q <= 32'h0000_0000;
      end else if (CE) begin
         ack_q   <= req;
         wait_q  <= ~req;
         rdata_q <= rd_take ? rdata_d : rdata_q;
      end
   end

   always_ff @(posedge CLK or negedge RESETN) begin
      if (!RESETN) begin
         trial_q  <= 8'h00;
         active_q <= 1'b0;
         irq_q    <= 1'b0;
         wake_q   <= 1'b0;
      end else if (CE) begin
         trial_q  <= trial;
         active_q <= busy;
         irq_q    <= irq_en_d & done_d;
         wake_q   <= irq_en_d & done_d & WAIT_MODE & ~STOP_MODE;
      end
   end

   // ------------------------------------------------------------
   // Outputs
   // ------------------------------------------------------------
   // validity shown by flag
   assign AVS_READDATA       = rdata_q;
   // Waitrequest high until the registered answer is ready
   assign AVS_WAITREQUEST    = wait_q;
   assign SAR_TRIAL          = trial_q;
   assign CONV_ACTIVE        = active_q;
   assign CONVERTER_POWER_ON = pwr_q;
   assign MAIN_OSC_DISABLE   = osc_off_q;
   assign COMPLETION_IRQ     = irq_q;
   assign WAKE_REQUEST       = wake_q;
endmodule // adcc_top

// File: verification/adcc_props.sv
`timescale 1ns/100ps
`include "adcc_defines.svh"
module adcc_props
   import adcc_pkg::*;
#(
   parameter int STEP_CYCLES = `ADCC_STEP_CYCLES
) (
   input wire logic                    CLK,
   input wire logic                    RESETN,
   input wire logic                    CE,
   input wire logic [`ADCC_ADDR_W-1:0] AVS_ADDRESS,
   input wire logic                    AVS_READ,
   input wire logic                    AVS_WRITE,
   input wire logic [31:0]             AVS_WRITEDATA,
   input wire logic [3:0]              AVS_BYTEENABLE,
   input wire logic [31:0]             AVS_READDATA,
   input wire logic                    AVS_WAITREQUEST,
   input wire logic                    WAIT_MODE,
   input wire logic                    STOP_MODE,
   input wire logic                    CONV_ACTIVE,
   input wire logic                    CONVERTER_POWER_ON,
   input wire logic                    MAIN_OSC_DISABLE,
   input wire logic                    COMPLETION_IRQ,
   input wire logic                    WAKE_REQUEST
);
   // -----------------------------------------
   // Accepted control write
   // -----------------------------------------
   localparam logic [`ADCC_ADDR_W-1:0] ctrl_addr = `ADCC_ADDR_W'({`ADCC_IDX_CTRL, 2'b00});
   // Writes land on the edge that answers them
   wire logic ctl = AVS_WRITE && !AVS_WAITREQUEST && CE && AVS_BYTEENABLE[0]
                    && AVS_ADDRESS == ctrl_addr;
   default clocking @(posedge CLK); endclocking
   default disable iff (!RESETN);
   sequence take_s; (AVS_READ || AVS_WRITE) && AVS_WAITREQUEST && CE; endsequence
   sequence start_s; ctl && AVS_WRITEDATA[5] && AVS_WRITEDATA[4] && !STOP_MODE; endsequence
   sequence wake_s; WAIT_MODE && !STOP_MODE && COMPLETION_IRQ; endsequence
   // -----------------------------------------
   // Properties
   // -----------------------------------------
   bus_answer_a:
      assert property (take_s |=> !AVS_WAITREQUEST ##1 AVS_WAITREQUEST) else $error("bad answer");
   bus_idle_a:
      assert property (!AVS_READ && !AVS_WRITE |=> AVS_WAITREQUEST) else $error("idle answer");
   read_zero_a:
      assert property (!AVS_WAITREQUEST && AVS_READ && AVS_ADDRESS == ctrl_addr
         |-> (AVS_READDATA & 32'hFFFF_FF2B) == 32'h0000_0000) else $error("bits not zero");
   osc_follow_a:
      assert property (ctl |-> ##2 MAIN_OSC_DISABLE == $past(AVS_WRITEDATA[2], 2))
         else $error("osc bit");
   power_follow_a:
      assert property (ctl |-> ##2 CONVERTER_POWER_ON == $past(AVS_WRITEDATA[4], 2))
         else $error("power bit");
   conv_start_a:
      assert property (start_s |-> ##[1:3] CONV_ACTIVE) else $error("no start");
   flag_clear_a:
      assert property (start_s |-> ##2 !COMPLETION_IRQ) else $error("flag kept");
   irq_mask_a:
      assert property (ctl && !AVS_WRITEDATA[7] |-> ##2 !COMPLETION_IRQ) else $error("irq unmasked");
   no_wake_a:
      assert property (STOP_MODE || !WAIT_MODE |=> !WAKE_REQUEST) else $error("stray wake");
   wake_up_a:
      assert property (wake_s ##1 wake_s |-> WAKE_REQUEST) else $error("missing wake");
   stop_abort_a:
      assert property (STOP_MODE |-> ##[1:3] !CONV_ACTIVE) else $error("runs in stop");
endmodule // adcc_props

bind adcc_top adcc_props #(.STEP_CYCLES(STEP_CYCLES)) adcc_props_inst (
   .CLK(CLK), .RESETN(RESETN), .CE(CE), .AVS_ADDRESS(AVS_ADDRESS), .AVS_READ(AVS_READ),
   .AVS_WRITE(AVS_WRITE), .AVS_WRITEDATA(AVS_WRITEDATA), .AVS_BYTEENABLE(AVS_BYTEENABLE),
   .AVS_READDATA(AVS_READDATA), .AVS_WAITREQUEST(AVS_WAITREQUEST), .WAIT_MODE(WAIT_MODE),
   .STOP_MODE(STOP_MODE), .CONV_ACTIVE(CONV_ACTIVE), .CONVERTER_POWER_ON(CONVERTER_POWER_ON),
   .MAIN_OSC_DISABLE(MAIN_OSC_DISABLE), .COMPLETION_IRQ(COMPLETION_IRQ),
   .WAKE_REQUEST(WAKE_REQUEST));

// File: verification/tb_top.sv
`timescale 1ns/100ps
`include "adcc_defines.svh"
module tb_top;
   localparam logic [9:0] ctrl_a = `ADCC_ADDR_W'({`ADCC_IDX_CTRL, 2'b00});
   localparam logic [9:0] res_a  = `ADCC_ADDR_W'({`ADCC_IDX_RESULT, 2'b00});
   logic        ce     = 1'b1;
   logic        clk    = 1'b0;
   logic        resetn = 1'b0;
   logic        rd     = 1'b0;
   logic        wr     = 1'b0;
   logic        above  = 1'b0;
   logic        below  = 1'b0;
   logic        wmode  = 1'b0;
   logic        smode  = 1'b0;
   logic [9:0]  addr   = 10'h000;
   logic [31:0] wdata  = 32'h0000_0000;
   logic [7:0]  ain    = 8'h00;
   logic [7:0]  trial;
   logic [31:0] rdata;
   logic [31:0] q;
   logic        waitreq, busy, pwr, osc, irq, wake;
   int          err_count = 0;
   int          checks_done = 0;
   // Input sits half a code above ain, so the result settles on ain
   wire logic   cmp = {ain, 1'b1} > {trial, 1'b0};
   wire logic [31:0] outs = {27'h000_0000, busy, pwr, osc, irq, wake};

   always #25 clk = ~clk;

   adcc_top #(.STEP_CYCLES(2)) adcc_top_inst (
      .CLK(clk), .RESETN(resetn), .CE(ce), .AVS_ADDRESS(addr), .AVS_READ(rd),
      .AVS_WRITE(wr), .AVS_WRITEDATA(wdata), .AVS_BYTEENABLE(4'hF), .AVS_READDATA(rdata),
      .AVS_WAITREQUEST(waitreq), .CMP_HIGH(cmp), .ABOVE_HIGH_REF(above),
      .BELOW_LOW_REF(below), .WAIT_MODE(wmode), .STOP_MODE(smode), .SAR_TRIAL(trial),
      .CONV_ACTIVE(busy), .CONVERTER_POWER_ON(pwr), .MAIN_OSC_DISABLE(osc),
      .COMPLETION_IRQ(irq), .WAKE_REQUEST(wake));

   // -----------------------------------------
   // Tasks
   // -----------------------------------------
   task ck(input logic [31:0] g, input logic [31:0] e);
      checks_done++;
      if (g !== e) begin
         err_count++;
         $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e);
      end
   endtask
   task rq(input logic w, input logic [9:0] a, input logic [7:0] d);
      @(posedge clk);
      addr <= a;
      wdata <= {24'h00_0000, d};
      wr <= w;
      rd <= !w;
      do @(posedge clk); while (waitreq !== 1'b0);
      q = rdata;
      wr <= 1'b0;
      rd <= 1'b0;
   endtask
   task rc(input logic [9:0] a, input logic [7:0] e);
      rq(1'b0, a, 8'h00);
      ck(q, {24'h00_0000, e});
   endtask
   task cv;
      repeat (3) @(posedge clk);
      while (busy !== 1'b0) @(posedge clk);
      repeat (3) @(posedge clk);
   endtask
   task results;
      if (err_count == 0 && checks_done > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask

   // -----------------------------------------
   // Tests
   // -----------------------------------------
   initial begin
      repeat (4) @(posedge clk);
      resetn <= 1'b1;
      rc(ctrl_a, `ADCC_CTRL_RESET);
      rc(10'h000, 8'h00);
      rq(1'b1, ctrl_a, 8'h84);
      rc(ctrl_a, 8'hC4);
      rq(1'b1, ctrl_a, 8'hA4);
      rc(ctrl_a, 8'hC4);
      @(negedge clk);
      ck(outs, 32'h0000_0006);
      rq(1'b1, ctrl_a, 8'h14);
      ain <= 8'hA5;
      rq(1'b1, ctrl_a, 8'h34);
      rc(ctrl_a, 8'h14);
      cv;
      rc(ctrl_a, 8'h54);
      rc(res_a, 8'hA5);
      @(negedge clk);
      ck(outs, 32'h0000_000C);
      @(posedge clk);
      wmode <= 1'b1;
      rq(1'b1, ctrl_a, 8'h94);
      repeat (3) @(negedge clk);
      ck(outs, 32'h0000_000F);
      @(posedge clk);
      smode <= 1'b1;
      rq(1'b1, ctrl_a, 8'hB4);
      repeat (3) @(negedge clk);
      ck(outs & 32'h0000_0011, 32'h0000_0000);
      rq(1'b1, ctrl_a, 8'h14);
      @(negedge clk);
      ck(outs & 32'h0000_0002, 32'h0000_0000);
      @(posedge clk);
      smode <= 1'b0;
      wmode <= 1'b0;
      ain <= 8'h3C;
      rq(1'b1, ctrl_a, 8'h34);
      repeat (8) @(posedge clk);
      ain <= 8'hC3;
      rq(1'b1, ctrl_a, 8'h34);
      repeat (6) @(posedge clk);
      rc(ctrl_a, 8'h14);
      cv;
      rc(res_a, 8'hC3);
      rq(1'b1, ctrl_a, 8'h34);
      @(posedge clk);
      ce <= 1'b0;
      repeat (40) @(posedge clk);
      @(negedge clk);
      ck(outs & 32'h0000_0010, 32'h0000_0010);
      @(posedge clk);
      ce <= 1'b1;
      repeat (4) @(posedge clk);
      rq(1'b1, ctrl_a, 8'h00);
      repeat (30) @(posedge clk);
      rc(ctrl_a, 8'h00);
      for (int i = 0; i < 2; i++) begin
         above <= (i == 0);
         below <= (i == 1);
         rq(1'b1, ctrl_a, 8'h10);
         rq(1'b1, ctrl_a, 8'h30);
         cv;
         rc(res_a, i == 0 ? `ADCC_FULL_SCALE : `ADCC_ZERO_SCALE);
      end
      rq(1'b1, res_a, 8'h77);
      rc(res_a, `ADCC_ZERO_SCALE);
      results;
   end

   // Generous bound; the sequence needs well under a thousand cycles
   initial begin
      repeat (4000) @(posedge clk);
      err_count++;
      results;
   end
endmodule // tb_top
